// ==== hw/isl_defs.svh ====
`ifndef ISL_DEFS_SVH
`define ISL_DEFS_SVH

// widths
`define ISL_PC_W 21
`define ISL_NPINS 7
`define ISL_NSRC 5
`define ISL_AW 8

// pin vector layout: three edge pins, then port pins 7..4
`define ISL_PIN_EXT0 0
`define ISL_PIN_EXT1 1
`define ISL_PIN_EXT2 2
`define ISL_PIN_PORT_LO 3
`define ISL_PIN_PORT_HI 6

// register byte offsets
`define ISL_OFF_CTRL_MAIN 8'h00
`define ISL_OFF_CTRL_SECOND 8'h04
`define ISL_OFF_CTRL_THIRD 8'h08
`define ISL_OFF_RESET_CAUSE 8'h0C
`define ISL_OFF_TIMER_CNT 8'h10
`define ISL_OFF_TIMER_CFG 8'h14
`define ISL_OFF_PORT_B 8'h18

// irq_ctrl_main fields
`define ISL_MAIN_GIEH 7
`define ISL_MAIN_GIEL 6
`define ISL_MAIN_TMR_EN 5
`define ISL_MAIN_EXT0_EN 4
`define ISL_MAIN_PORT_EN 3
`define ISL_MAIN_TMR_FLAG 2
`define ISL_MAIN_EXT0_FLAG 1
`define ISL_MAIN_PORT_FLAG 0
// irq_ctrl_second fields
`define ISL_SEC_EDGE0 6
`define ISL_SEC_EDGE1 5
`define ISL_SEC_EDGE2 4
`define ISL_SEC_TMR_PRIO 2
`define ISL_SEC_PORT_PRIO 0
// irq_ctrl_third fields
`define ISL_THR_EXT2_PRIO 7
`define ISL_THR_EXT1_PRIO 6
`define ISL_THR_EXT2_EN 4
`define ISL_THR_EXT1_EN 3
`define ISL_THR_EXT2_FLAG 1
`define ISL_THR_EXT1_FLAG 0
// reset_cause_control and timer config fields
`define ISL_RCC_PRIO_EN 7
`define ISL_TCFG_MODE16 0

// writable masks and reset values
`define ISL_MASK_MAIN 8'hFF
`define ISL_MASK_SECOND 8'h75
`define ISL_MASK_THIRD 8'hDB
`define ISL_MASK_RCC 8'h80
`define ISL_RST_MAIN 8'h00
`define ISL_RST_SECOND 8'h75
`define ISL_RST_THIRD 8'hC0
`define ISL_RST_RCC 8'h00

// timer limits
`define ISL_T8_MAX 8'hFF
`define ISL_T16_MAX 16'hFFFF
`define ISL_TCNT_RST 16'h0000

`endif

// ==== hw/isl_pkg.sv ====
`default_nettype none
`include "isl_defs.svh"

package isl_pkg;

	// bus phase of the register slave
	typedef enum logic [1:0] {
		ISL_PH_IDLE = 2'b00,
		ISL_PH_WRITE = 2'b01
	} isl_phase_e;

	// pin synchroniser state
	typedef struct packed {
		logic [`ISL_NPINS-1:0] s1;
		logic [`ISL_NPINS-1:0] s2;
		logic [`ISL_NPINS-1:0] s3;
		logic [`ISL_NPINS-1:0] level;
		logic [`ISL_NPINS-1:0] rise;
		logic [`ISL_NPINS-1:0] fall;
	} isl_sync_s;

	// context save state
	typedef struct packed {
		logic push;
		logic [`ISL_PC_W-1:0] stack_pc;
		logic [7:0] sh_work;
		logic [7:0] sh_status;
		logic [7:0] sh_bank;
	} isl_ctx_s;

	// main block state
	typedef struct packed {
		logic [7:0] main;
		logic [7:0] second;
		logic [7:0] third;
		logic [7:0] rcc;
		logic [15:0] tcount;
		logic mode16;
		logic [3:0] port_snap;
		logic [2:0] wake_en;
		logic sleep_d;
		isl_phase_e phase;
		logic [`ISL_AW-1:0] waddr;
		logic [31:0] hrdata;
		logic hready;
		logic irq_hi;
		logic irq_lo;
		logic wake;
		logic wake_branch;
	} isl_top_s;

endpackage

`default_nettype wire

// ==== hw/isl_ifs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "isl_defs.svh"

// filtered pin levels and their edges
interface isl_pin_if;
	logic [`ISL_NPINS-1:0] level;
	logic [`ISL_NPINS-1:0] rise;
	logic [`ISL_NPINS-1:0] fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface

// core context in, saved context out
interface isl_ctx_if;
	logic entry;
	logic [`ISL_PC_W-1:0] pc;
	logic [7:0] work;
	logic [7:0] status;
	logic [7:0] bank;
	logic push;
	logic [`ISL_PC_W-1:0] stack_pc;
	logic [7:0] sh_work;
	logic [7:0] sh_status;
	logic [7:0] sh_bank;
	modport keeper (input entry, input pc, input work, input status,
		input bank, output push, output stack_pc, output sh_work,
		output sh_status, output sh_bank);
endinterface

`default_nettype wire

// ==== hw/isl_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "isl_defs.svh"

module isl_pin_sync (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [`ISL_NPINS-1:0] pins_in,
	isl_pin_if.src pin
);
	isl_pkg::isl_sync_s st_ff;
	isl_pkg::isl_sync_s nxt_st;
	logic [`ISL_NPINS-1:0] agree;

	// three stages; a level is accepted once stages two and three agree
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.s1 = pins_in;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		agree = ~(st_ff.s2 ^ st_ff.s3);
		nxt_st.level = (agree & st_ff.s3) | (~agree & st_ff.level);
		nxt_st.rise = nxt_st.level & ~st_ff.level;
		nxt_st.fall = ~nxt_st.level & st_ff.level;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign pin.level = st_ff.level;
	assign pin.rise = st_ff.rise;
	assign pin.fall = st_ff.fall;

endmodule

`default_nettype wire

// ==== hw/isl_ctx_save.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "isl_defs.svh"

module isl_ctx_save (
	input wire logic clk_in,
	input wire logic rst_in,
	isl_ctx_if.keeper cx
);
	isl_pkg::isl_ctx_s st_ff;
	isl_pkg::isl_ctx_s nxt_st;

	// one-deep shadow: a second entry overwrites the first
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.push = cx.entry;
		if (cx.entry)
		begin
			nxt_st.stack_pc = cx.pc;
			nxt_st.sh_work = cx.work;
			nxt_st.sh_status = cx.status;
			nxt_st.sh_bank = cx.bank;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign cx.push = st_ff.push;
	assign cx.stack_pc = st_ff.stack_pc;
	assign cx.sh_work = st_ff.sh_work;
	assign cx.sh_status = st_ff.sh_status;
	assign cx.sh_bank = st_ff.sh_bank;

	property p_push;
		@(posedge clk_in) disable iff (rst_in)
		cx.entry |=> (st_ff.push && st_ff.stack_pc == $past(cx.pc));
	endproperty
	a_push: assert property (p_push)
		else $error("return pc not pushed on entry");

	property p_shadow;
		@(posedge clk_in) disable iff (rst_in)
		cx.entry ##1 !cx.entry |-> (st_ff.sh_work == $past(cx.work)
			&& st_ff.sh_status == $past(cx.status)
			&& st_ff.sh_bank == $past(cx.bank)) ##1 (st_ff.sh_bank ==
			$past(st_ff.sh_bank));
	endproperty
	a_shadow: assert property (p_shadow)
		else $error("shadow copy wrong or not held");

endmodule

`default_nettype wire

// ==== hw/isl_irq_top.sv ====
// Function
// - edge select 1 rising, 0 falling
// - selected edge sets pin flag
// - cleared enable blocks request, flag still sets
// - enabled external pins wake from idle/sleep
// - wake branches to vector only if enabled
// - pin one/two priorities in third register
// - pin zero always high priority
// - 8-bit timer wrap sets flag
// - 16-bit timer wrap sets flag
// - timer enable at main bit 5
// - timer priority at second bit 2
// - port pins 7..4 change sets flag
// - port change enable at main bit 3
// - port change priority at second bit 0
// - entry pushes return pc
// - entry copies work, status, bank registers
// - priority enable picks two or one level
// - priority bit 1 high, 0 low
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "isl_defs.svh"

module isl_irq_top (
	input wire logic REF_CLK_IN,
	input wire logic RESET_IN,
	input wire logic HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic [2:0] HSIZE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic HREADY_IN,
	output logic [31:0] HRDATA_OUT,
	output logic HREADYOUT_OUT,
	output logic HRESP_OUT,
	input wire logic [2:0] EXT_PINS_IN,
	input wire logic [3:0] PORT_B_HI_IN,
	input wire logic TIMER_TICK_IN,
	input wire logic CORE_SLEEP_IN,
	input wire logic CORE_ENTRY_IN,
	input wire logic [`ISL_PC_W-1:0] CORE_PC_IN,
	input wire logic [7:0] CORE_WORK_IN,
	input wire logic [7:0] CORE_STATUS_IN,
	input wire logic [7:0] CORE_BANK_IN,
	output logic IRQ_HIGH_OUT,
	output logic IRQ_LOW_OUT,
	output logic WAKE_OUT,
	output logic WAKE_BRANCH_OUT,
	output logic STACK_PUSH_OUT,
	output logic [`ISL_PC_W-1:0] STACK_PC_OUT,
	output logic [7:0] SHADOW_WORK_OUT,
	output logic [7:0] SHADOW_STATUS_OUT,
	output logic [7:0] SHADOW_BANK_OUT
);
	isl_pkg::isl_top_s st_ff;
	isl_pkg::isl_top_s nxt_st;
	logic take;
	logic wr_timer;
	logic tmr_wrap;
	logic [2:0] ext_ev;
	logic [2:0] ext_en;
	logic [2:0] ext_flag;
	logic [`ISL_NSRC-1:0] pend;
	logic [`ISL_NSRC-1:0] prio;
	logic prio_on;
	logic [3:0] port_now;

	isl_pin_if pin ();
	isl_ctx_if cx ();

	// merge a written byte into a register under its writable mask
	function automatic logic [7:0] wr_bits(input logic [7:0] old,
		input logic [7:0] data, input logic [7:0] mask);
		wr_bits = (old & ~mask) | (data & mask);
	endfunction

	isl_pin_sync u_sync (
		.clk_in(REF_CLK_IN),
		.rst_in(RESET_IN),
		.pins_in({PORT_B_HI_IN, EXT_PINS_IN}),
		.pin(pin.src)
	);

	// core side of the context saver
	assign cx.entry = CORE_ENTRY_IN;
	assign cx.pc = CORE_PC_IN;
	assign cx.work = CORE_WORK_IN;
	assign cx.status = CORE_STATUS_IN;
	assign cx.bank = CORE_BANK_IN;

	isl_ctx_save u_ctx (
		.clk_in(REF_CLK_IN),
		.rst_in(RESET_IN),
		.cx(cx.keeper)
	);

	// source views gathered from the control registers
	always_comb
	begin
		port_now = pin.level[`ISL_PIN_PORT_HI:`ISL_PIN_PORT_LO];
		prio_on = st_ff.rcc[`ISL_RCC_PRIO_EN];
		ext_en = {st_ff.third[`ISL_THR_EXT2_EN],
			st_ff.third[`ISL_THR_EXT1_EN],
			st_ff.main[`ISL_MAIN_EXT0_EN]};
		ext_flag = {st_ff.third[`ISL_THR_EXT2_FLAG],
			st_ff.third[`ISL_THR_EXT1_FLAG],
			st_ff.main[`ISL_MAIN_EXT0_FLAG]};
		// each edge pin looks for the edge its select bit names
		ext_ev[0] = st_ff.second[`ISL_SEC_EDGE0] ?
			pin.rise[`ISL_PIN_EXT0] : pin.fall[`ISL_PIN_EXT0];
		ext_ev[1] = st_ff.second[`ISL_SEC_EDGE1] ?
			pin.rise[`ISL_PIN_EXT1] : pin.fall[`ISL_PIN_EXT1];
		ext_ev[2] = st_ff.second[`ISL_SEC_EDGE2] ?
			pin.rise[`ISL_PIN_EXT2] : pin.fall[`ISL_PIN_EXT2];
		// pending = flag and enable; flags set regardless of enable
		pend = {ext_flag[2] & ext_en[2], ext_flag[1] & ext_en[1],
			st_ff.main[`ISL_MAIN_PORT_FLAG] &
			st_ff.main[`ISL_MAIN_PORT_EN],
			st_ff.main[`ISL_MAIN_TMR_FLAG] &
			st_ff.main[`ISL_MAIN_TMR_EN],
			ext_flag[0] & ext_en[0]};
		// pin zero has no priority bit and counts as high
		prio = {st_ff.third[`ISL_THR_EXT2_PRIO],
			st_ff.third[`ISL_THR_EXT1_PRIO],
			st_ff.second[`ISL_SEC_PORT_PRIO],
			st_ff.second[`ISL_SEC_TMR_PRIO],
			1'b1};
	end

	// bus, register writes, events and request outputs
	always_comb
	begin
		nxt_st = st_ff;
		wr_timer = 1'b0;
		take = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
		nxt_st.hready = 1'b1;
		nxt_st.phase = isl_pkg::ISL_PH_IDLE;
		// write data phase; unmapped offsets are dropped
		if (st_ff.phase == isl_pkg::ISL_PH_WRITE)
		begin
			if (st_ff.waddr == `ISL_OFF_CTRL_MAIN)
				nxt_st.main = wr_bits(st_ff.main, HWDATA_IN[7:0],
					`ISL_MASK_MAIN);
			else if (st_ff.waddr == `ISL_OFF_CTRL_SECOND)
				nxt_st.second = wr_bits(st_ff.second, HWDATA_IN[7:0],
					`ISL_MASK_SECOND);
			else if (st_ff.waddr == `ISL_OFF_CTRL_THIRD)
				nxt_st.third = wr_bits(st_ff.third, HWDATA_IN[7:0],
					`ISL_MASK_THIRD);
			else if (st_ff.waddr == `ISL_OFF_RESET_CAUSE)
				nxt_st.rcc = wr_bits(st_ff.rcc, HWDATA_IN[7:0],
					`ISL_MASK_RCC);
			else if (st_ff.waddr == `ISL_OFF_TIMER_CNT)
			begin
				nxt_st.tcount = HWDATA_IN[15:0];
				wr_timer = 1'b1;
			end
			else if (st_ff.waddr == `ISL_OFF_TIMER_CFG)
				nxt_st.mode16 = HWDATA_IN[`ISL_TCFG_MODE16];
		end
		// timer counts on the tick; a load wins over the tick
		tmr_wrap = 1'b0;
		if (TIMER_TICK_IN && !wr_timer)
		begin
			if (st_ff.mode16)
			begin
				tmr_wrap = (st_ff.tcount == `ISL_T16_MAX);
				nxt_st.tcount = 16'(st_ff.tcount + 16'h0001);
			end
			else
			begin
				tmr_wrap = (st_ff.tcount[7:0] == `ISL_T8_MAX);
				nxt_st.tcount[7:0] = 8'(st_ff.tcount[7:0] + 8'h01);
			end
		end
		// hardware sets after the software write: set wins
		if (ext_ev[0])
			nxt_st.main[`ISL_MAIN_EXT0_FLAG] = 1'b1;
		if (ext_ev[1])
			nxt_st.third[`ISL_THR_EXT1_FLAG] = 1'b1;
		if (ext_ev[2])
			nxt_st.third[`ISL_THR_EXT2_FLAG] = 1'b1;
		if (tmr_wrap)
			nxt_st.main[`ISL_MAIN_TMR_FLAG] = 1'b1;
		// level compare, so the flag re-sets until the port is read
		if (port_now != st_ff.port_snap)
			nxt_st.main[`ISL_MAIN_PORT_FLAG] = 1'b1;
		// address phase: reads answer next cycle from the flop
		if (take)
		begin
			if (HWRITE_IN)
			begin
				nxt_st.phase = isl_pkg::ISL_PH_WRITE;
				nxt_st.waddr = HADDR_IN[`ISL_AW-1:0];
			end
			else if (HADDR_IN[`ISL_AW-1:0] == `ISL_OFF_CTRL_MAIN)
				nxt_st.hrdata = {24'h00_0000, st_ff.main};
			else if (HADDR_IN[`ISL_AW-1:0] == `ISL_OFF_CTRL_SECOND)
				nxt_st.hrdata = {24'h00_0000, st_ff.second};
			else if (HADDR_IN[`ISL_AW-1:0] == `ISL_OFF_CTRL_THIRD)
				nxt_st.hrdata = {24'h00_0000, st_ff.third};
			else if (HADDR_IN[`ISL_AW-1:0] == `ISL_OFF_RESET_CAUSE)
				nxt_st.hrdata = {24'h00_0000, st_ff.rcc};
			else if (HADDR_IN[`ISL_AW-1:0] == `ISL_OFF_TIMER_CNT)
				nxt_st.hrdata = {16'h0000, st_ff.tcount};
			else if (HADDR_IN[`ISL_AW-1:0] == `ISL_OFF_TIMER_CFG)
				nxt_st.hrdata = {31'h0000_0000, st_ff.mode16};
			else if (HADDR_IN[`ISL_AW-1:0] == `ISL_OFF_PORT_B)
			begin
				nxt_st.hrdata = {24'h00_0000, port_now, 4'h0};
				nxt_st.port_snap = port_now;
			end
			else
				nxt_st.hrdata = 32'h0000_0000;
		end
		// two levels or one, global enables gate everything
		if (prio_on)
		begin
			nxt_st.irq_hi = (|(pend & prio)) &&
				st_ff.main[`ISL_MAIN_GIEH];
			nxt_st.irq_lo = (|(pend & ~prio)) &&
				st_ff.main[`ISL_MAIN_GIEH] &&
				st_ff.main[`ISL_MAIN_GIEL];
		end
		else
		begin
			nxt_st.irq_hi = (|pend) && st_ff.main[`ISL_MAIN_GIEH];
			nxt_st.irq_lo = 1'b0;
		end
		// enables are sampled as the core enters idle or sleep
		nxt_st.sleep_d = CORE_SLEEP_IN;
		if (CORE_SLEEP_IN && !st_ff.sleep_d)
			nxt_st.wake_en = ext_en;
		nxt_st.wake = CORE_SLEEP_IN && st_ff.sleep_d &&
			(|(ext_flag & st_ff.wake_en));
		nxt_st.wake_branch = nxt_st.wake &&
			st_ff.main[`ISL_MAIN_GIEH];
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (RESET_IN)
		begin
			st_ff <= '0;
			st_ff.main <= `ISL_RST_MAIN;
			st_ff.second <= `ISL_RST_SECOND;
			st_ff.third <= `ISL_RST_THIRD;
			st_ff.rcc <= `ISL_RST_RCC;
			st_ff.tcount <= `ISL_TCNT_RST;
			st_ff.hready <= 1'b1;
		end
		else
			st_ff <= nxt_st;
	end

	// every output but HRESP_OUT, tied low, is a flop of this module or of the saver
	assign HRDATA_OUT = st_ff.hrdata;
	assign HREADYOUT_OUT = st_ff.hready;
	assign HRESP_OUT = 1'b0;
	assign IRQ_HIGH_OUT = st_ff.irq_hi;
	assign IRQ_LOW_OUT = st_ff.irq_lo;
	assign WAKE_OUT = st_ff.wake;
	assign WAKE_BRANCH_OUT = st_ff.wake_branch;
	assign STACK_PUSH_OUT = cx.push;
	assign STACK_PC_OUT = cx.stack_pc;
	assign SHADOW_WORK_OUT = cx.sh_work;
	assign SHADOW_STATUS_OUT = cx.sh_status;
	assign SHADOW_BANK_OUT = cx.sh_bank;

	property p_ext_rise;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		(pin.rise[`ISL_PIN_EXT0] && st_ff.second[`ISL_SEC_EDGE0])
			|=> st_ff.main[`ISL_MAIN_EXT0_FLAG];
	endproperty
	a_ext_rise: assert property (p_ext_rise)
		else $error("rising edge did not set pin zero flag");

	property p_ext_fall;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		(pin.fall[`ISL_PIN_EXT1] && !st_ff.second[`ISL_SEC_EDGE1])
			|=> st_ff.third[`ISL_THR_EXT1_FLAG];
	endproperty
	a_ext_fall: assert property (p_ext_fall)
		else $error("falling edge did not set pin one flag");

	property p_mask;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		(ext_en == 3'h0 && !st_ff.main[`ISL_MAIN_TMR_EN] &&
			!st_ff.main[`ISL_MAIN_PORT_EN])
			|=> (!st_ff.irq_hi && !st_ff.irq_lo);
	endproperty
	a_mask: assert property (p_mask)
		else $error("request raised with every enable clear");

	property p_wake;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		($rose(CORE_SLEEP_IN) && ext_en == 3'h0) ##1 CORE_SLEEP_IN[*2]
			|=> !st_ff.wake;
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake from a pin not enabled at entry");

	property p_wake_branch;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		st_ff.wake_branch |-> (st_ff.wake &&
			$past(st_ff.main[`ISL_MAIN_GIEH]));
	endproperty
	a_wake_branch: assert property (p_wake_branch)
		else $error("branch after wake without global enable");

	property p_ext1_prio;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		(prio_on && st_ff.main[`ISL_MAIN_GIEH] && pend[3] &&
			st_ff.third[`ISL_THR_EXT1_PRIO]) |=> st_ff.irq_hi;
	endproperty
	a_ext1_prio: assert property (p_ext1_prio)
		else $error("pin one high priority not honoured");

	property p_ext0_high;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		(prio_on && st_ff.main[`ISL_MAIN_GIEH] && pend[0]) |=> st_ff.irq_hi;
	endproperty
	a_ext0_high: assert property (p_ext0_high)
		else $error("pin zero not raised as high priority");

	property p_tmr8;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		(TIMER_TICK_IN && !st_ff.mode16 &&
			st_ff.tcount[7:0] == `ISL_T8_MAX &&
			st_ff.phase == isl_pkg::ISL_PH_IDLE)
			|=> (st_ff.main[`ISL_MAIN_TMR_FLAG] && st_ff.tcount[7:0] == 8'h00);
	endproperty
	a_tmr8: assert property (p_tmr8)
		else $error("8-bit timer wrap missed");

	property p_tmr16;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		(TIMER_TICK_IN && st_ff.mode16 && st_ff.tcount == `ISL_T16_MAX &&
			st_ff.phase == isl_pkg::ISL_PH_IDLE)
			|=> (st_ff.main[`ISL_MAIN_TMR_FLAG] &&
			st_ff.tcount == `ISL_TCNT_RST);
	endproperty
	a_tmr16: assert property (p_tmr16)
		else $error("16-bit timer wrap missed");

	property p_port;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		(port_now != st_ff.port_snap) |=> st_ff.main[`ISL_MAIN_PORT_FLAG];
	endproperty
	a_port: assert property (p_port)
		else $error("port change did not set flag");

	property p_single;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		!prio_on |=> !st_ff.irq_lo;
	endproperty
	a_single: assert property (p_single)
		else $error("low request with priority levels off");

	c_high: cover property (@(posedge REF_CLK_IN) $rose(st_ff.irq_hi));
	c_low: cover property (@(posedge REF_CLK_IN) $rose(st_ff.irq_lo));
	c_wake: cover property (@(posedge REF_CLK_IN) st_ff.wake_branch);
	c_tmr: cover property (@(posedge REF_CLK_IN) tmr_wrap);

endmodule

`default_nettype wire

// ==== verif/isl_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// board side of the pins: levels follow the bench request, late or later
module isl_pin_model (
	input wire logic clk_in,
	input wire logic slow_in,
	input wire logic [6:0] req_in,
	output logic [2:0] ext_out,
	output logic [3:0] port_out
);
	logic [6:0] d1 = 7'h00;
	logic [6:0] d2 = 7'h00;
	logic [6:0] d3 = 7'h00;
	logic [6:0] d4 = 7'h00;

	// slow mode adds settling, so edge capture must not assume one cycle
	always @(posedge clk_in)
	begin
		d1 <= req_in;
		d2 <= d1;
		d3 <= d2;
		d4 <= d3;
	end

	// pins are always driven by the board, never left floating
	assign {port_out, ext_out} = slow_in ? d4 : d1;
endmodule
`default_nettype wire

// ==== verif/interrupt_source_logic_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module interrupt_source_logic_tb;
	typedef struct packed {
		logic w;
		logic [7:0] a;
		logic [15:0] d;
		logic [15:0] e;
	} isl_row_s;
	logic clk = 0, rst = 1, hsel = 1, hwr = 0, tick = 0, slp = 0, ent = 0;
	logic slow = 0, hrdy, hresp, irqh, irql, wk, wkb, push;
	logic [1:0] htr = 2'h0;
	logic [31:0] ha = 32'h0000_0000, hwd = 32'h0000_0000, rd, hrd;
	logic [6:0] preq = 7'h00;
	logic [20:0] pc = 21'h00_0000, spc;
	logic [7:0] wr = 8'h00, st = 8'h00, bs = 8'h00, sw, ss, sb;
	logic [2:0] ext;
	logic [3:0] prt;
	int n_fail = 0, comparisons = 0;
	// per source: main, third, second prio and third prio bits
	logic [7:0] sm [5] = '{8'h12, 8'h00, 8'h00, 8'h24, 8'h09};
	logic [7:0] st3 [5] = '{8'h00, 8'h09, 8'h12, 8'h00, 8'h00};
	logic [7:0] sp2 [5] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h01};
	logic [7:0] sp3 [5] = '{8'h00, 8'h40, 8'h80, 8'h00, 8'h00};
	logic [15:0] ts [4] = '{16'h00FE, 16'h00FE, 16'h00FF, 16'hFFFE};
	logic [15:0] te [4] = '{16'h00FF, 16'h0000, 16'h0100, 16'h0000};
	// register table: write (optional) then read back
	isl_row_s rows [16] = '{
		'{1'h0, 8'h00, 16'h0000, 16'h0000}, '{1'h0, 8'h04, 16'h0000, 16'h0075},
		'{1'h0, 8'h08, 16'h0000, 16'h00C0}, '{1'h0, 8'h0C, 16'h0000, 16'h0000},
		'{1'h0, 8'h10, 16'h0000, 16'h0000}, '{1'h0, 8'h14, 16'h0000, 16'h0000},
		'{1'h1, 8'h04, 16'hFFFF, 16'h0075}, '{1'h1, 8'h08, 16'hFFFF, 16'h00DB},
		'{1'h1, 8'h08, 16'h0000, 16'h0000}, '{1'h1, 8'h0C, 16'hFFFF, 16'h0080},
		'{1'h1, 8'h0C, 16'h0000, 16'h0000}, '{1'h1, 8'h1C, 16'h00A5, 16'h0000},
		'{1'h1, 8'h10, 16'h1234, 16'h1234}, '{1'h1, 8'h14, 16'h0001, 16'h0001},
		'{1'h1, 8'h14, 16'h0000, 16'h0000}, '{1'h1, 8'h10, 16'h0000, 16'h0000}};

	isl_irq_top dut (
		.REF_CLK_IN(clk), .RESET_IN(rst), .HSEL_IN(hsel), .HADDR_IN(ha),
		.HTRANS_IN(htr), .HWRITE_IN(hwr), .HSIZE_IN(3'h2), .HWDATA_IN(hwd),
		.HREADY_IN(hrdy), .HRDATA_OUT(hrd), .HREADYOUT_OUT(hrdy),
		.HRESP_OUT(hresp), .EXT_PINS_IN(ext), .PORT_B_HI_IN(prt),
		.TIMER_TICK_IN(tick), .CORE_SLEEP_IN(slp), .CORE_ENTRY_IN(ent),
		.CORE_PC_IN(pc), .CORE_WORK_IN(wr), .CORE_STATUS_IN(st),
		.CORE_BANK_IN(bs), .IRQ_HIGH_OUT(irqh), .IRQ_LOW_OUT(irql),
		.WAKE_OUT(wk), .WAKE_BRANCH_OUT(wkb), .STACK_PUSH_OUT(push),
		.STACK_PC_OUT(spc), .SHADOW_WORK_OUT(sw), .SHADOW_STATUS_OUT(ss),
		.SHADOW_BANK_OUT(sb));

	isl_pin_model pins (.clk_in(clk), .slow_in(slow), .req_in(preq),
		.ext_out(ext), .port_out(prt));

	// free running clock
	initial
	begin
		forever #50 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// single word transfer; waits on ready, takes read data at that edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		htr <= 2'h2;
		ha <= {24'h00_0000, a};
		hwr <= w;
		do @(posedge clk); while (hrdy !== 1'b1);
		htr <= 2'h0;
		hwd <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		rd = hrd;
	endtask

	// software clears every flag itself, leaving global high on
	task automatic clr;
		bus(1, 8'h00, 32'h0000_0080);
		bus(1, 8'h08, 32'h0000_0000);
	endtask

	// pin change, long enough for synchroniser and slow board
	task automatic pin(input int b, input logic v);
		preq[b] <= v;
		repeat (12) @(posedge clk);
	endtask

	task automatic fl(input int i, input logic e);
		bus(0, (i == 0) ? 8'h00 : 8'h08, 32'h0000_0000);
		chk((i == 0) ? rd[1] : rd[i - 1], e);
	endtask

	task automatic note(input string s);
		$display("%s done: %0d checks, %0d errors", s, comparisons, n_fail);
	endtask

	task automatic results;
		$display("%0d comparisons, %0d mismatches", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// main sequence
	initial
	begin
		logic h;
		repeat (20) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		chk(hrdy, 1);
		chk({irqh, irql, wk, wkb, push}, 0);
		foreach (rows[r])
		begin
			if (rows[r].w)
				bus(1, rows[r].a, {16'h0000, rows[r].d});
			bus(0, rows[r].a, 32'h0000_0000);
			chk(rd, {16'h0000, rows[r].e});
			chk(hresp, 0);
		end
		note("registers");
		// pin driven high then low under each select: unselected edge first with falling select, selected edge first with rising
		clr;
		for (int i = 0; i < 3; i++)
		begin
			bus(1, 8'h04, 32'h0000_0075 & ~(32'h0000_0001 << (6 - i)));
			pin(i, 1);
			fl(i, 0);
			pin(i, 0);
			fl(i, 1);
			chk(irqh, 0);
			clr;
			bus(1, 8'h04, 32'h0000_0075);
			pin(i, 1);
			fl(i, 1);
			clr;
			pin(i, 0);
			fl(i, 0);
		end
		note("edges");
		// every source with global gating, the four with priority bits at both levels and pin zero high both times, then single-level mode
		bus(1, 8'h0C, 32'h0000_0080);
		for (int s = 0; s < 5; s++)
			for (int p = 0; p < 2; p++)
			begin
				bus(1, 8'h04, 8'h70 | (p ? sp2[s] : 8'h00));
				bus(1, 8'h08, st3[s] | (p ? sp3[s] : 8'h00));
				bus(1, 8'h00, 8'hC0 | sm[s]);
				repeat (2) @(posedge clk);
				h = p || s == 0;
				chk(irqh, h);
				chk(irql, !h);
				bus(1, 8'h00, 8'h80 | sm[s]);
				repeat (2) @(posedge clk);
				chk({irqh, irql}, {h, 1'b0});
				bus(1, 8'h00, 8'h40 | sm[s]);
				repeat (2) @(posedge clk);
				chk({irqh, irql}, 0);
				clr;
			end
		bus(1, 8'h0C, 32'h0000_0000);
		bus(1, 8'h08, 32'h0000_0009);
		repeat (2) @(posedge clk);
		chk({irqh, irql}, 2'h2);
		clr;
		note("priority");
		for (int k = 0; k < 4; k++)
		begin
			bus(1, 8'h14, k / 2);
			bus(1, 8'h10, {16'h0000, ts[k]});
			bus(1, 8'h00, 32'h0000_0000);
			tick <= 1;
			repeat (k % 2 + 1) @(posedge clk);
			tick <= 0;
			repeat (3) @(posedge clk);
			bus(0, 8'h10, 32'h0000_0000);
			chk(rd, {16'h0000, te[k]});
			bus(0, 8'h00, 32'h0000_0000);
			chk(rd[2], k % 2);
		end
		note("timer");
		// slow board; each port B read re-arms the compare snapshot
		slow <= 1;
		bus(0, 8'h18, 32'h0000_0000);
		bus(1, 8'h00, 32'h0000_0000);
		for (int k = 0; k < 4; k++)
		begin
			pin(3 + k, 1);
			bus(0, 8'h00, 32'h0000_0000);
			chk(rd[0], 1);
			bus(0, 8'h18, 32'h0000_0000);
			chk(rd, {24'h00_0000, 4'hF >> (3 - k), 4'h0});
			bus(1, 8'h00, 32'h0000_0000);
			repeat (3) @(posedge clk);
			bus(0, 8'h00, 32'h0000_0000);
			chk(rd[0], 0);
		end
		note("port change");
		// enable before sleep wakes; enable set during sleep does not
		bus(1, 8'h00, 32'h0000_0010);
		slp <= 1;
		repeat (2) @(posedge clk);
		pin(0, 1);
		chk({wk, wkb}, 2'h2);
		bus(1, 8'h00, 32'h0000_0092);
		repeat (2) @(posedge clk);
		chk({wk, wkb}, 2'h3);
		slp <= 0;
		pin(0, 0);
		bus(1, 8'h00, 32'h0000_0000);
		slp <= 1;
		repeat (2) @(posedge clk);
		bus(1, 8'h00, 32'h0000_0010);
		pin(0, 1);
		chk(wk, 0);
		slp <= 0;
		pin(0, 0);
		note("wake");
		// two entries three cycles apart with inverted context
		for (int k = 0; k < 2; k++)
		begin
			pc <= 21'h0A_5A5A ^ {21{k[0]}};
			{wr, st, bs} <= {8'h3C, 8'h5A, 8'hC3} ^ {24{k[0]}};
			ent <= 1;
			@(posedge clk);
			ent <= 0;
			@(posedge clk);
			chk(push, 1);
			chk(spc, 21'h0A_5A5A ^ {21{k[0]}});
			chk({sw, ss, sb}, {8'h3C, 8'h5A, 8'hC3} ^ {24{k[0]}});
			@(posedge clk);
			chk(push, 0);
		end
		note("context");
		// second reset in mid-run
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		chk({push, spc, sw, ss, sb, wk, wkb}, 0);
		bus(0, 8'h04, 32'h0000_0000);
		chk(rd, 32'h0000_0075);
		bus(0, 8'h0C, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		note("reset");
		results;
	end

	// watchdog well beyond the expected run of under a thousand cycles
	initial
	begin
		#2000000;
		n_fail++;
		results;
	end
endmodule
`default_nettype wire
